/* File: ocb_blank_timer.sv */
`timescale 1ns/1ps
// One shared blanking timer, reloaded on every gate edge
module ocb_blank_timer (
    // Clock, reset, enable
    input  wire logic                            ref_clk,
    input  wire logic                            rst_n,
    input  wire logic                            clkEn,
    // Control
    input  wire logic [ocb_pkg::BLANK_SEL_W-1:0] blankSel,
    input  wire logic                            gateEdge,
    // Status
    output logic      [ocb_pkg::BLANK_CNT_W-1:0] blankRemain,
    output logic                                 blanking
);

    // Count down; any edge reloads, so a burst of edges keeps extending
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blankRemain <= '0;
        end
        else if (clkEn)
        begin
            if (blankSel == '0)
            begin
                // No-delay setting cancels any blanking at once
                blankRemain <= '0;
            end
            else if (gateEdge)
            begin
                // Start, or restart from this edge
                blankRemain <= ocb_pkg::ocbBlankCycles(blankSel);
            end
            else if (blankRemain != '0)
            begin
                blankRemain <= blankRemain - 1'b1;
            end
        end
    end

    // Active while time remains
    assign blanking = (blankRemain != '0);

endmodule : ocb_blank_timer

/* File: ocb_mcu_model.sv */
`timescale 1ns/1ps
// Controller model: launches its PWM pattern just after each rising edge
module ocb_mcu_model (
    // Clock
    input  wire logic       ref_clk,
    // Pattern asked for by the bench
    input  wire logic [2:0] highCmd,
    input  wire logic [2:0] lowCmd,
    // PWM pins toward the driver
    output logic      [2:0] pwmHigh,
    output logic      [2:0] pwmLow
);
    // Low side yields to high side, so a leg never shoots through
    always @(posedge ref_clk)
    begin
        pwmHigh <= highCmd;
        pwmLow  <= lowCmd & ~highCmd;
    end
endmodule : ocb_mcu_model

/* File: ocb_pkg.sv */
// Shared constants for the overcurrent and blanking protection block
package ocb_pkg;

    // Clock rate
    localparam int CLK_PERIOD_NS = 100;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_BLANK  = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_DRVCFG = 8'h0c;

    // Field positions
    localparam int CTRL_EN_BIT    = 0;
    localparam int BLANK_SEL_LSB  = 0;
    localparam int BLANK_SEL_W    = 2;
    localparam int STS_VDS_LSB    = 0;
    localparam int STS_SHUT_BIT   = 6;
    localparam int STS_CBC_LSB    = 7;
    localparam int STS_BLANK_BIT  = 10;
    localparam int CFG_LEVEL_LSB  = 0;
    localparam int CFG_LEVEL_W    = 5;
    localparam int CFG_LATCH_BIT  = 5;

    // Reset values
    localparam logic                   CTRL_EN_RST = 1'b0;
    localparam logic [BLANK_SEL_W-1:0] BLANK_RST   = 2'h0;
    localparam logic [CFG_LEVEL_W-1:0] LEVEL_RST   = 5'h00;
    localparam logic                   LATCH_RST   = 1'b1;

    // Blanking options in ns, and their cycle counts (rounded up)
    localparam int BLANK_A_NS  = 500;
    localparam int BLANK_B_NS  = 1000;
    localparam int BLANK_C_NS  = 2000;
    localparam int BLANK_A_CYC = (BLANK_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_B_CYC = (BLANK_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_C_CYC = (BLANK_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_CNT_W = 5;

    // Longest allowed comparator-to-gate-off time (rounded down)
    localparam int CBC_RESP_NS  = 1000;
    localparam int CBC_RESP_CYC = CBC_RESP_NS / CLK_PERIOD_NS;

    // Blanking select to load value
    function automatic logic [BLANK_CNT_W-1:0] ocbBlankCycles(
        input logic [BLANK_SEL_W-1:0] sel
    );
        case (sel)
            2'h1:    ocbBlankCycles = BLANK_CNT_W'(BLANK_A_CYC);
            2'h2:    ocbBlankCycles = BLANK_CNT_W'(BLANK_B_CYC);
            2'h3:    ocbBlankCycles = BLANK_CNT_W'(BLANK_C_CYC);
            default: ocbBlankCycles = '0;
        endcase
    endfunction : ocbBlankCycles

endpackage : ocb_pkg

/* File: ocb_protect.sv */
`timescale 1ns/1ps
module ocb_protect (
    // Clock, reset, enable
    input  wire logic                            ref_clk,
    input  wire logic                            rst_n,
    input  wire logic                            clkEn,
    // Wishbone slave
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    input  wire logic                            wb_we_i,
    input  wire logic [7:0]                      wb_adr_i,
    input  wire logic [3:0]                      wb_sel_i,
    input  wire logic [31:0]                     wb_dat_i,
    output logic      [31:0]                     wb_dat_o,
    output logic                                 wb_ack_o,
    // Controller PWM pins
    input  wire logic [2:0]                      pwmHighIn,
    input  wire logic [2:0]                      pwmLowIn,
    // Analog trip inputs
    input  wire logic [2:0]                      senseAtRefIn,
    input  wire logic [5:0]                      drainSourceTripIn,
    // Gate drive outputs
    output logic      [2:0]                      gateHigh,
    output logic      [2:0]                      gateLow,
    // Comparator and blanking outputs
    output logic      [2:0]                      compOutN,
    output logic                                 senseBlanked,
    // Trip level to analog comparators, fault pin
    output logic      [ocb_pkg::CFG_LEVEL_W-1:0] drain_source_trip_level,
    output logic                                 fault_indicator_n
);

    // Synchronised pins
    logic [2:0] pwmHighSync;         // PWM high request
    logic [2:0] pwmLowSync;          // PWM low request
    logic [2:0] senseAtRefSync;      // Amplified sense at reference
    logic [5:0] tripSync;            // Per-transistor drain-source trip

    // Registers
    logic                            driveEnReg;                 // Gate enable
    logic [ocb_pkg::BLANK_SEL_W-1:0] blankSelReg;                // Blanking option
    logic                            drain_source_latch_select;  // Latch mode
    logic [5:0]                      tripFlagReg;                // Sticky trip record
    logic                            shutdownReg;                // Latched shutdown
    logic [2:0]                      cbcReg;                     // Per-phase limit
    logic [2:0]                      pwmHighPrev;                // For PWM rise detect
    logic [5:0]                      gatePrev;                   // For gate edge detect
    logic                            ackReg;                     // Bus ack

    // Combinational terms
    logic                                 busReq;
    logic                                 wrCommit;
    logic                                 stsWrite;
    logic [2:0]                           cbcNext;
    logic                                 shutdownNext;
    logic                                 gateEdge;
    logic                                 blanking;
    logic [ocb_pkg::BLANK_CNT_W-1:0]      blankRemain;
    logic [31:0]                          readData;

    // Pin synchronisers
    ocb_sync #(.W(12)) uPinSync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .asyncIn ({pwmHighIn, pwmLowIn, drainSourceTripIn}),
        .syncOut ({pwmHighSync, pwmLowSync, tripSync})
    );

    ocb_sync #(.W(3)) uSenseSync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .asyncIn (senseAtRefIn),
        .syncOut (senseAtRefSync)
    );

    // Shared blanking timer
    ocb_blank_timer uBlank (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .clkEn       (clkEn),
        .blankSel    (blankSelReg),
        .gateEdge    (gateEdge),
        .blankRemain (blankRemain),
        .blanking    (blanking)
    );

    // Bus decode; write lands on the edge that sees ack high
    assign busReq   = wb_cyc_i & wb_stb_i;
    assign wrCommit = clkEn & busReq & ackReg & wb_we_i & wb_sel_i[0];
    assign stsWrite = wrCommit & (wb_adr_i == ocb_pkg::OFF_STATUS);
    assign wb_ack_o = ackReg;

    // Ack one cycle after request, dropped the cycle after
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ackReg <= 1'b0;
        else if (clkEn)
            ackReg <= busReq & ~ackReg;
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        readData = '0;
        case (wb_adr_i)
            ocb_pkg::OFF_CTRL:   readData[ocb_pkg::CTRL_EN_BIT] = driveEnReg;
            ocb_pkg::OFF_BLANK:
                readData[ocb_pkg::BLANK_SEL_LSB +: ocb_pkg::BLANK_SEL_W] = blankSelReg;
            ocb_pkg::OFF_STATUS:
            begin
                readData[ocb_pkg::STS_VDS_LSB +: 6] = tripFlagReg;
                readData[ocb_pkg::STS_SHUT_BIT]     = shutdownReg;
                readData[ocb_pkg::STS_CBC_LSB +: 3] = cbcReg;
                readData[ocb_pkg::STS_BLANK_BIT]    = blanking;
            end
            ocb_pkg::OFF_DRVCFG:
            begin
                readData[ocb_pkg::CFG_LEVEL_LSB +: ocb_pkg::CFG_LEVEL_W] =
                    drain_source_trip_level;
                readData[ocb_pkg::CFG_LATCH_BIT] = drain_source_latch_select;
            end
            default: readData = '0;
        endcase
    end

    // Read data captured as ack rises
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            wb_dat_o <= '0;
        else if (clkEn && busReq && !ackReg)
            wb_dat_o <= readData;
    end

    // Control, blanking and driver configuration registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            driveEnReg                <= ocb_pkg::CTRL_EN_RST;
            blankSelReg               <= ocb_pkg::BLANK_RST;
            drain_source_trip_level   <= ocb_pkg::LEVEL_RST;
            drain_source_latch_select <= ocb_pkg::LATCH_RST;
        end
        else if (wrCommit)
        begin
            case (wb_adr_i)
                ocb_pkg::OFF_CTRL:   driveEnReg <= wb_dat_i[ocb_pkg::CTRL_EN_BIT];
                ocb_pkg::OFF_BLANK:
                    blankSelReg <= wb_dat_i[ocb_pkg::BLANK_SEL_LSB +: ocb_pkg::BLANK_SEL_W];
                ocb_pkg::OFF_DRVCFG:
                begin
                    // Level and mode always written as one word
                    drain_source_trip_level <=
                        wb_dat_i[ocb_pkg::CFG_LEVEL_LSB +: ocb_pkg::CFG_LEVEL_W];
                    drain_source_latch_select <= wb_dat_i[ocb_pkg::CFG_LATCH_BIT];
                end
                default: driveEnReg <= driveEnReg;
            endcase
        end
    end

    // Sticky per-transistor trip record, write one to clear, set wins
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            tripFlagReg <= '0;
        else if (clkEn)
        begin
            if (stsWrite)
                tripFlagReg <= (tripFlagReg & ~wb_dat_i[ocb_pkg::STS_VDS_LSB +: 6])
                               | tripSync;
            else
                tripFlagReg <= tripFlagReg | tripSync;
        end
    end

    // Latched shutdown only in latch mode; a new trip beats the clear
    assign shutdownNext = (drain_source_latch_select & (|tripSync))
                        | (shutdownReg & ~(stsWrite & wb_dat_i[ocb_pkg::STS_SHUT_BIT]));

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            shutdownReg <= 1'b0;
        else if (clkEn)
            shutdownReg <= shutdownNext;
    end

    // Fault pin follows any recorded trip, registered
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            fault_indicator_n <= 1'b1;
        else if (clkEn)
            fault_indicator_n <= ~(|(tripFlagReg | tripSync));
    end

    // Comparator: low at reference, held high while blanked for all phases
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            compOutN <= 3'h7;
        else if (clkEn)
            compOutN <= ~(senseAtRefSync & {3{~blanking}});
    end

    // Cycle limit: set by low comparator, released at next PWM rise
    always_comb
    begin
        cbcNext = (cbcReg & ~(pwmHighSync & ~pwmHighPrev)) | ~compOutN;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cbcReg      <= '0;
            pwmHighPrev <= '0;
        end
        else if (clkEn)
        begin
            cbcReg      <= cbcNext;
            pwmHighPrev <= pwmHighSync;
        end
    end

    // Gate drive; shutdown and limit act in the same edge as their cause
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gateHigh <= '0;
            gateLow  <= '0;
        end
        else if (clkEn)
        begin
            if (!driveEnReg || shutdownNext)
            begin
                gateHigh <= '0;
                gateLow  <= '0;
            end
            else
            begin
                // Limit overrides a high controller PWM
                gateHigh <= pwmHighSync & ~cbcNext;
                gateLow  <= pwmLowSync;
            end
        end
    end

    // Edge detect over all six gate outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            gatePrev <= '0;
        else if (clkEn)
            gatePrev <= {gateHigh, gateLow};
    end

    assign gateEdge     = ({gateHigh, gateLow} != gatePrev);
    assign senseBlanked = blanking;

    // Checks
    default clocking cbClk @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_edge_blank;
        clkEn && gateEdge && blankSelReg != 2'h0 |=> blanking;
    endproperty
    a_edge_blank: assert property (p_edge_blank) else $error("edge did not blank");

    property p_common_blank;
        clkEn && blanking |=> compOutN == 3'h7;
    endproperty
    a_common_blank: assert property (p_common_blank) else $error("phase not blanked");

    property p_restart;
        clkEn && gateEdge && blankSelReg == 2'h1
            |=> blankRemain == ocb_pkg::BLANK_CNT_W'(ocb_pkg::BLANK_A_CYC);
    endproperty
    a_restart: assert property (p_restart) else $error("blanking not restarted");

    property p_no_blank;
        clkEn && blankSelReg == 2'h0 |=> !blanking;
    endproperty
    a_no_blank: assert property (p_no_blank) else $error("blanked with no delay");

    property p_comp_low;
        clkEn && !blanking && senseAtRefSync[0] |=> !compOutN[0];
    endproperty
    a_comp_low: assert property (p_comp_low) else $error("comparator stayed high");

    property p_force_off;
        clkEn && compOutN != 3'h7 |=> (gateHigh & ~$past(compOutN)) == 3'h0;
    endproperty
    a_force_off: assert property (p_force_off) else $error("high side not forced off");

    property p_latch_off;
        clkEn && drain_source_latch_select && tripSync != 6'h00
            |=> gateHigh == 3'h0 && gateLow == 3'h0 ##1 shutdownReg;
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("gates not pulled low");

    property p_fault_pin;
        clkEn && tripSync != 6'h00 |=> !fault_indicator_n;
    endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("fault pin not asserted");

    property p_record;
        clkEn && tripSync != 6'h00 |=> (tripFlagReg & $past(tripSync)) == $past(tripSync);
    endproperty
    a_record: assert property (p_record) else $error("trip not recorded");

    property p_hold;
        clkEn && shutdownReg && !stsWrite |=> shutdownReg;
    endproperty
    a_hold: assert property (p_hold) else $error("shutdown released early");

    c_restart:  cover property (blanking && gateEdge && clkEn);
    c_limit:    cover property (cbcReg != 3'h0 ##[1:50] cbcReg == 3'h0);
    c_shutdown: cover property (shutdownReg ##1 stsWrite ##1 !shutdownReg);

endmodule : ocb_protect

/* File: ocb_protect_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the protection block
module ocb_protect_tb;
    // Clock, reset, enable
    logic        ref_clk    = 1'b0;
    logic        rst_n      = 1'b0;
    logic        clkEn      = 1'b1;
    // Wishbone master side
    logic        wbCyc      = 1'b0;
    logic        wbStb      = 1'b0;
    logic        wbWe       = 1'b0;
    logic [7:0]  wbAdr      = 8'h00;
    logic [3:0]  wbSel      = 4'hf;
    logic [31:0] wbDatW     = 32'h0;
    logic [31:0] wbDatR;
    logic        wbAck;
    // Pins
    logic [2:0]  highCmd    = 3'h0;
    logic [2:0]  lowCmd     = 3'h0;
    logic [2:0]  pwmHigh;
    logic [2:0]  pwmLow;
    logic [2:0]  senseAtRef = 3'h0;
    logic [5:0]  dsTrip     = 6'h00;
    logic [2:0]  gateHigh;
    logic [2:0]  gateLow;
    logic [2:0]  compOutN;
    logic        senseBlanked;
    logic [4:0]  tripLevel;
    logic        faultN;
    // Bookkeeping
    int          err_total   = 0;
    int          comparisons = 0;
    int          cycleCount  = 0;
    int          len;
    int          n;
    logic        sawLow;
    // Blanking edge cases: rise and fall on a high and a low gate
    logic [2:0]  caseH [4]  = '{3'h1, 3'h0, 3'h0, 3'h0};
    logic [2:0]  caseL [4]  = '{3'h0, 3'h0, 3'h4, 3'h0};
    // Reset table: address and expected word
    logic [7:0]  rstAdr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] rstVal [5] = '{32'h0, 32'h0, 32'h0, 32'h20, 32'h0};

    // 100 ns clock
    always #50 ref_clk = ~ref_clk;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk)
    begin
        cycleCount++;
        if (cycleCount == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    ocb_mcu_model u_mcu (
        .ref_clk (ref_clk),
        .highCmd (highCmd),
        .lowCmd  (lowCmd),
        .pwmHigh (pwmHigh),
        .pwmLow  (pwmLow)
    );

    ocb_protect u_dut (
        .ref_clk                 (ref_clk),
        .rst_n                   (rst_n),
        .clkEn                   (clkEn),
        .wb_cyc_i                (wbCyc),
        .wb_stb_i                (wbStb),
        .wb_we_i                 (wbWe),
        .wb_adr_i                (wbAdr),
        .wb_sel_i                (wbSel),
        .wb_dat_i                (wbDatW),
        .wb_dat_o                (wbDatR),
        .wb_ack_o                (wbAck),
        .pwmHighIn               (pwmHigh),
        .pwmLowIn                (pwmLow),
        .senseAtRefIn            (senseAtRef),
        .drainSourceTripIn       (dsTrip),
        .gateHigh                (gateHigh),
        .gateLow                 (gateLow),
        .compOutN                (compOutN),
        .senseBlanked            (senseBlanked),
        .drain_source_trip_level (tripLevel),
        .fault_indicator_n       (faultN)
    );

    // Verdict and stop
    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // Register word compare
    task automatic chk_reg(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk_reg

    // Pin compare
    task automatic chk_pin(input string what, input logic [5:0] e, input logic [5:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk_pin

    // One classic cycle; held until ack is sampled, then released
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] rd);
        int k;
        k = 0;
        @(posedge ref_clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= a;
        wbDatW <= d;
        // Ack is read at the rising edge, before that edge updates it
        do
        begin
            @(posedge ref_clk);
            k++;
        end while (wbAck !== 1'b1 && k < 40);
        if (wbAck !== 1'b1)
        begin
            err_total++;
            $display("MISMATCH bus ack expected 1 seen %b", wbAck);
        end
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
    endtask : wb_xfer

    // Write one word
    task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        wb_xfer(1'b1, a, d, unused);
    endtask : wb_write

    // Read one word, compare the masked bits
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        logic [31:0] rd;
        wb_xfer(1'b0, a, 32'h0, rd);
        chk_reg(what, e & m, rd & m);
    endtask : rd_chk

    // Controller pattern change at a rising edge
    task automatic set_pwm(input logic [2:0] h, input logic [2:0] l);
        @(posedge ref_clk);
        highCmd <= h;
        lowCmd  <= l;
    endtask : set_pwm

    // Length of the next blanking run; notes any comparator low inside it
    task automatic blank_len(output int ln, output logic low);
        int k;
        k   = 0;
        ln  = 0;
        low = 1'b0;
        while (senseBlanked !== 1'b1 && k < 50)
        begin
            @(negedge ref_clk);
            k++;
        end
        while (senseBlanked === 1'b1 && ln < 60)
        begin
            if (compOutN !== 3'h7)
                low = 1'b1;
            ln++;
            @(negedge ref_clk);
        end
    endtask : blank_len

    // Main sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk_pin("fault pin at reset", 6'h1, faultN);
        chk_pin("comparators at reset", 6'h7, compOutN);
        chk_pin("blanking at reset", 6'h0, senseBlanked);
        for (int i = 0; i < 5; i++)
            rd_chk("reset value", rstAdr[i], 32'hffffffff, rstVal[i]);
        // No blanking while the setting is still at its default
        wb_write(ocb_pkg::OFF_CTRL, 32'h1);
        set_pwm(3'h2, 3'h0);
        blank_len(len, sawLow);
        chk_reg("blank length default", 32'h0, len);
        set_pwm(3'h0, 3'h0);
        repeat (10) @(posedge ref_clk);
        // Every kind of gate edge opens a 500 ns window
        wb_write(ocb_pkg::OFF_BLANK, 32'h1);
        rd_chk("blank select", ocb_pkg::OFF_BLANK, 32'h3, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            set_pwm(caseH[i], caseL[i]);
            blank_len(len, sawLow);
            chk_reg("blank length", ocb_pkg::BLANK_A_CYC, len);
            repeat (10) @(posedge ref_clk);
        end
        // Second edge two cycles later restarts; sense on all phases stays masked
        set_pwm(3'h1, 3'h0);
        fork
            blank_len(len, sawLow);
            begin
                @(posedge ref_clk);
                set_pwm(3'h0, 3'h0);
                @(posedge ref_clk);
                senseAtRef <= 3'h7;
                repeat (2) @(posedge ref_clk);
                senseAtRef <= 3'h0;
            end
        join
        chk_reg("blank restart length", ocb_pkg::BLANK_A_CYC + 2, len);
        chk_pin("comparator low in blanking", 6'h0, sawLow);
        // Longer options: 1000 ns and 2000 ns
        for (int s = 2; s < 4; s++)
        begin
            wb_write(ocb_pkg::OFF_BLANK, 32'(s));
            set_pwm(3'(s), 3'h0);
            blank_len(len, sawLow);
            n = (s == 2) ? ocb_pkg::BLANK_B_CYC : ocb_pkg::BLANK_C_CYC;
            chk_reg("blank length long", n, len);
        end
        wb_write(ocb_pkg::OFF_BLANK, 32'h0);
        // Cycle-by-cycle limit on phase 1
        set_pwm(3'h2, 3'h1);
        repeat (6) @(posedge ref_clk);
        chk_pin("gates before limit", 6'h11, {gateHigh, gateLow});
        senseAtRef <= 3'h2;
        n = 0;
        while (gateHigh[1] !== 1'b0 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk_reg("limit response", 32'h1, 32'(n <= ocb_pkg::CBC_RESP_CYC));
        chk_pin("comparator out", 6'h5, compOutN);
        rd_chk("limit status", ocb_pkg::OFF_STATUS, 32'h380, 32'h100);
        @(posedge ref_clk);
        senseAtRef <= 3'h0;
        repeat (6) @(posedge ref_clk);
        chk_pin("limit held", 6'h0, gateHigh);
        set_pwm(3'h0, 3'h1);
        repeat (4) @(posedge ref_clk);
        set_pwm(3'h2, 3'h1);
        repeat (6) @(posedge ref_clk);
        chk_pin("limit released", 6'h2, gateHigh);
        // Latched drain-source trip on transistor 4
        wb_write(ocb_pkg::OFF_DRVCFG, 32'h2d);
        rd_chk("drive config", ocb_pkg::OFF_DRVCFG, 32'h3f, 32'h2d);
        chk_pin("trip level pins", 6'h0d, tripLevel);
        @(posedge ref_clk);
        dsTrip <= 6'h10;
        repeat (3) @(posedge ref_clk);
        dsTrip <= 6'h00;
        repeat (3) @(posedge ref_clk);
        chk_pin("gates after trip", 6'h0, {gateHigh, gateLow});
        chk_pin("fault pin on trip", 6'h0, faultN);
        rd_chk("trip status", ocb_pkg::OFF_STATUS, 32'h7f, 32'h50);
        repeat (10) @(posedge ref_clk);
        chk_pin("shutdown held", 6'h0, {gateHigh, gateLow});
        wb_write(ocb_pkg::OFF_STATUS, 32'h50);
        rd_chk("status cleared", ocb_pkg::OFF_STATUS, 32'h7f, 32'h0);
        repeat (4) @(posedge ref_clk);
        chk_pin("fault pin cleared", 6'h1, faultN);
        chk_pin("gates resumed", 6'h11, {gateHigh, gateLow});
        // Report-only mode: trip on transistor 0 leaves gates running
        wb_write(ocb_pkg::OFF_DRVCFG, 32'h0d);
        @(posedge ref_clk);
        dsTrip <= 6'h01;
        repeat (3) @(posedge ref_clk);
        dsTrip <= 6'h00;
        repeat (3) @(posedge ref_clk);
        chk_pin("gates report mode", 6'h11, {gateHigh, gateLow});
        chk_pin("fault pin report mode", 6'h0, faultN);
        rd_chk("report status", ocb_pkg::OFF_STATUS, 32'h7f, 32'h01);
        wb_write(ocb_pkg::OFF_STATUS, 32'h01);
        repeat (3) @(posedge ref_clk);
        chk_pin("fault pin released", 6'h1, faultN);
        end_of_test();
    end
endmodule : ocb_protect_tb

/* File: ocb_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of pin inputs
module ocb_sync #(
    parameter int W = 1
) (
    // Clock, reset, enable
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         clkEn,
    // Data
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    logic [W-1:0] stage1Reg;   // Metastable stage, read only by stage two

    // Both stages freeze with the enable
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1Reg <= '0;
            syncOut   <= '0;
        end
        else if (clkEn)
        begin
            stage1Reg <= asyncIn;
            syncOut   <= stage1Reg;
        end
    end

endmodule : ocb_sync
